// >>> hw/adr_device.sv
// Functional notes
// [RULE1] 32-bit microsecond ticker, zero at reset, counts up
// [RULE2] ticker wraps from all ones to zero
// [RULE3] process interrupt captures ticker low 16 bits
// [RULE4] interrupt stamp holds only the low half
// [RULE5] diagnostic interrupts only when coupler enables them; the going interrupt of an active event is sent even with diag_en cleared
// [RULE6] diagnostic event: incoming interrupt, record offered
// [RULE7] cause gone: going interrupt without acknowledgement
// [RULE8] events between incoming and going are dropped
// [RULE9] fault lamp lit from incoming to going
// [RULE10] record set 01h full, 00h first four bytes
// [RULE11] index 2F01h full, 2F00h first four bytes
// [RULE12] index 5005h: one subindex per record entry
// [RULE13] summary bits 0,1,2: failure, internal, external
// [RULE14] summary bit 3: any channel error
// [RULE15] summary bit 4: auxiliary supply missing
// [RULE16] summary bit 7: parameterization error
// [RULE17] module info class 0101b, analog module
// [RULE18] module info bit 4: channel info follows
// [RULE19] extended bits 3,4,6: overflow, comm, lost
// [RULE20] ticker advances once per microsecond by divider
// [RULE21] reserved bits and bytes read zero
`include "adr_params.svh"
`default_nettype none
module adr_device #(
   parameter int USEC_CYC = `ADR_USEC_CYC,
   parameter int CHANS = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   adr_link_if.dev link,
   input wire logic module_fail,
   input wire logic internal_err,
   input wire logic external_err,
   input wire logic aux_missing,
   input wire logic param_err,
   input wire logic diag_buf_overflow,
   input wire logic comm_err,
   input wire logic [CHANS-1:0][7:0] chan_err,
   input wire logic prit_event,
   input wire logic [1:0] prit_upper,
   input wire logic [1:0] prit_lower,
   output logic module_fault_lamp
);
   if (USEC_CYC < 1 || USEC_CYC > 65536) begin : g_bad_usec
      $error("adr_device: USEC_CYC out of range");
   end
   if (CHANS < 1 || CHANS > 8) begin : g_bad_chans
      $error("adr_device: CHANS must be 1 to 8");
   end

   adr_pkg::adr_dev_state_t s_q;
   adr_pkg::adr_dev_state_t s_d;

   // one byte of the record: 16 live bytes, then the diagnostic stamp
   function automatic logic [7:0] rec_byte(
      input logic [15:0][7:0] snap,
      input logic [31:0] stamp,
      input logic [4:0] idx
   );
      logic [7:0] b;
      b = 8'h00;
      if (idx < `ADR_POS_STAMP)
         b = snap[idx[3:0]];
      else if (idx < `ADR_REC_LEN)
         b = stamp[8 * (idx - `ADR_POS_STAMP) +: 8];
      return b;
   endfunction

   logic [15:0][7:0] live;
   logic [7:0] grp;
   logic cause;
   logic ok;
   logic [4:0] first;
   logic [4:0] last;

   always_comb begin
      live = '0; // [RULE21]
      grp = 8'h00;
      for (int i = 0; i < CHANS; i++) begin
         grp[i] = |chan_err[i];
         live[`ADR_POS_CHAN + i] = chan_err[i];
      end
      live[0] = {param_err, // [RULE16]
                 2'b00, // [RULE21]
                 aux_missing, // [RULE15]
                 |grp, // [RULE14]
                 external_err, internal_err, module_fail}; // [RULE13]
      live[1] = `ADR_MODINFO; // [RULE17] [RULE18]
      live[3] = {1'b0, s_q.lost, 1'b0, comm_err, diag_buf_overflow,
                 3'b000}; // [RULE19]
      live[4] = `ADR_CHKIND;
      live[5] = `ADR_DIAG_BITS_PER_CHANNEL;
      live[6] = 8'(CHANS);
      live[7] = grp;
      cause = (|live[0]) | (|live[3]);
   end

   always_comb begin
      s_d = s_q;
      s_d.din = 1'b0;
      s_d.dout = 1'b0;
      ok = 1'b0;
      first = 5'd0;
      last = 5'd0;

      // microsecond ticker
      if (s_q.div == 16'(USEC_CYC - 1)) begin // [RULE20]
         s_d.div = 16'h0000;
         s_d.tick = s_q.tick + 32'h1; // [RULE1] [RULE2]
      end else begin
         s_d.div = s_q.div + 16'h1;
      end

      // diagnostic interrupt: record frozen while active
      if (!s_q.active) begin
         s_d.snap = live;
         if (link.diag_en && cause) begin // [RULE5]
            s_d.active = 1'b1; // [RULE9]
            s_d.din = 1'b1; // [RULE6]
            s_d.dstamp = s_q.tick;
         end
      end else if (!cause) begin
         s_d.active = 1'b0; // [RULE9]
         s_d.dout = 1'b1; // [RULE7]
      end
      // while active the snapshot stays, later events are not kept [RULE8]

      // process interrupt, held until the coupler takes it
      if (link.prit_valid && link.prit_ready)
         s_d.prit_v = 1'b0;
      if (prit_event) begin
         if (s_d.prit_v) begin
            s_d.lost = 1'b1; // [RULE19]
         end else begin
            s_d.prit_v = 1'b1;
            s_d.prit_stamp = s_q.tick[15:0]; // [RULE3] [RULE4]
            s_d.upper = prit_upper;
            s_d.lower = prit_lower;
            s_d.lost = 1'b0;
         end
      end

      // record read
      case (s_q.st)
         adr_pkg::ADR_IDLE: begin
            if (link.req_valid) begin
               case (link.req_path)
                  adr_pkg::ADR_PATH_RECSET: begin
                     if (link.req_sel == `ADR_RS_FULL) begin // [RULE10]
                        ok = 1'b1;
                        last = `ADR_REC_LEN - 5'd1;
                     end else if (link.req_sel == `ADR_RS_HEAD) begin
                        ok = 1'b1;
                        last = `ADR_HEAD_LEN - 5'd1;
                     end
                  end
                  adr_pkg::ADR_PATH_CAN: begin
                     if (link.req_sel == `ADR_CAN_FULL) begin // [RULE11]
                        ok = 1'b1;
                        last = `ADR_REC_LEN - 5'd1;
                     end else if (link.req_sel == `ADR_CAN_HEAD) begin
                        ok = 1'b1;
                        last = `ADR_HEAD_LEN - 5'd1;
                     end
                  end
                  adr_pkg::ADR_PATH_ETH: begin
                     if (link.req_sel == `ADR_ETH_INDEX) begin // [RULE12]
                        if (link.req_sub >= `ADR_SX_FIRST &&
                            link.req_sub <= `ADR_SX_LAST) begin
                           ok = 1'b1;
                           first = 5'(link.req_sub - `ADR_SX_FIRST);
                           last = first;
                        end else if (link.req_sub == `ADR_SX_STAMP) begin
                           ok = 1'b1;
                           first = `ADR_POS_STAMP;
                           last = `ADR_REC_LEN - 5'd1;
                        end
                     end
                  end
                  default: ok = 1'b0;
               endcase
               s_d.st = adr_pkg::ADR_SEND;
               s_d.err = !ok;
               s_d.pos = first;
               s_d.last = last;
               s_d.data = ok ? rec_byte(s_d.snap, s_d.dstamp, first) : 8'h00;
            end
         end
         adr_pkg::ADR_SEND: begin
            if (link.rsp_ready) begin
               if (s_q.err || s_q.pos == s_q.last) begin
                  s_d.st = adr_pkg::ADR_IDLE;
               end else begin
                  s_d.pos = s_q.pos + 5'd1;
                  s_d.data = rec_byte(s_q.snap, s_q.dstamp, s_d.pos);
               end
            end
         end
         default: s_d.st = adr_pkg::ADR_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         s_q <= '0; // [RULE1]
      else
         s_q <= s_d;
   end

   assign link.req_ready = s_q.st == adr_pkg::ADR_IDLE;
   assign link.rsp_valid = s_q.st == adr_pkg::ADR_SEND;
   assign link.rsp_data = s_q.data;
   assign link.rsp_last = s_q.err || s_q.pos == s_q.last;
   assign link.rsp_err = s_q.err;
   assign link.diag_in = s_q.din;
   assign link.diag_out = s_q.dout;
   assign link.prit_valid = s_q.prit_v;
   assign link.prit_stamp = s_q.prit_stamp;
   assign link.prit_upper = s_q.upper;
   assign link.prit_lower = s_q.lower;
   assign module_fault_lamp = s_q.active; // [RULE9]
endmodule
`default_nettype wire

// >>> hw/adr_params.svh
`ifndef ADR_PARAMS_SVH
`define ADR_PARAMS_SVH

// timing
`define ADR_CLK_NS 20
`define ADR_USEC_NS 1000
`define ADR_USEC_CYC (`ADR_USEC_NS / `ADR_CLK_NS)

// record layout and fixed contents
`define ADR_REC_LEN 5'd20
`define ADR_HEAD_LEN 5'd4
`define ADR_POS_STAMP 5'd16
`define ADR_POS_CHAN 8
`define ADR_MODINFO 8'h15
`define ADR_CHKIND 8'h71
`define ADR_DIAG_BITS_PER_CHANNEL 8'h08
`define ADR_SUM_RESET 8'h00

// access paths
`define ADR_RS_FULL 16'h0001
`define ADR_RS_HEAD 16'h0000
`define ADR_CAN_FULL 16'h2f01
`define ADR_CAN_HEAD 16'h2f00
`define ADR_ETH_INDEX 16'h5005
`define ADR_SX_FIRST 8'h02
`define ADR_SX_LAST 8'h11
`define ADR_SX_STAMP 8'h13

// coupler register offsets
`define ADR_OFF_CTRL 6'h00
`define ADR_OFF_REQ 6'h01
`define ADR_OFF_STAT 6'h02
`define ADR_OFF_PRIT 6'h03
`define ADR_OFF_DATA 6'h04
`define ADR_OFF_DATA_END 6'h08

// status field positions
`define ADR_ST_BUSY 0
`define ADR_ST_DONE 1
`define ADR_ST_ERR 2
`define ADR_ST_ACTIVE 3
`define ADR_ST_SEEN_IN 4
`define ADR_ST_SEEN_OUT 5
`define ADR_ST_PRIT 6

`endif

// >>> hw/adr_pkg.sv
`default_nettype none
package adr_pkg;
   typedef enum logic [1:0] {ADR_PATH_RECSET, ADR_PATH_CAN, ADR_PATH_ETH}
      adr_path_t;
   typedef enum logic {ADR_IDLE, ADR_SEND} adr_rd_st_t;

   typedef struct packed {
      logic [15:0] div;
      logic [31:0] tick;
      logic active;
      logic [15:0][7:0] snap;
      logic [31:0] dstamp;
      logic din;
      logic dout;
      logic prit_v;
      logic [15:0] prit_stamp;
      logic [1:0] upper;
      logic [1:0] lower;
      logic lost;
      adr_rd_st_t st;
      logic [4:0] pos;
      logic [4:0] last;
      logic err;
      logic [7:0] data;
   } adr_dev_state_t;

   typedef struct packed {
      logic diag_en;
      logic aw_h;
      logic [5:0] aw_a;
      logic w_h;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [1:0] rr;
      logic [31:0] rd;
      logic [31:0] req;
      logic req_v;
      logic busy;
      logic done;
      logic err;
      logic [4:0] cnt;
      logic [19:0][7:0] rbuf;
      logic act;
      logic seen_in;
      logic seen_out;
      logic pend;
      logic [15:0] pstamp;
      logic [3:0] plim;
   } adr_cpl_state_t;
endpackage
`default_nettype wire

// >>> hw/adr_link_if.sv
`default_nettype none
interface adr_link_if;
   logic diag_en;
   logic req_valid;
   logic req_ready;
   adr_pkg::adr_path_t req_path;
   logic [15:0] req_sel;
   logic [7:0] req_sub;
   logic rsp_valid;
   logic rsp_ready;
   logic [7:0] rsp_data;
   logic rsp_last;
   logic rsp_err;
   logic diag_in;
   logic diag_out;
   logic prit_valid;
   logic prit_ready;
   logic [15:0] prit_stamp;
   logic [1:0] prit_upper;
   logic [1:0] prit_lower;

   modport dev (
      input diag_en, req_valid, req_path, req_sel, req_sub, rsp_ready,
      input prit_ready,
      output req_ready, rsp_valid, rsp_data, rsp_last, rsp_err,
      output diag_in, diag_out, prit_valid, prit_stamp, prit_upper,
      output prit_lower
   );
   modport cpl (
      output diag_en, req_valid, req_path, req_sel, req_sub, rsp_ready,
      output prit_ready,
      input req_ready, rsp_valid, rsp_data, rsp_last, rsp_err,
      input diag_in, diag_out, prit_valid, prit_stamp, prit_upper,
      input prit_lower
   );
endinterface
`default_nettype wire

// >>> hw/adr_coupler.sv
`include "adr_params.svh"
`default_nettype none
module adr_coupler (
   input wire logic aclk,
   input wire logic aresetn,
   adr_link_if.cpl link,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   adr_pkg::adr_cpl_state_t s_q;
   adr_pkg::adr_cpl_state_t s_d;
   logic [31:0] m;
   logic [31:0] stat;
   logic [5:0] ra;

   always_comb begin
      stat = 32'h0;
      stat[`ADR_ST_BUSY] = s_q.busy;
      stat[`ADR_ST_DONE] = s_q.done;
      stat[`ADR_ST_ERR] = s_q.err;
      stat[`ADR_ST_ACTIVE] = s_q.act;
      stat[`ADR_ST_SEEN_IN] = s_q.seen_in;
      stat[`ADR_ST_SEEN_OUT] = s_q.seen_out;
      stat[`ADR_ST_PRIT] = s_q.pend;
      stat[12:8] = s_q.cnt;
   end

   always_comb begin
      s_d = s_q;
      ra = s_axi_araddr[7:2];
      for (int i = 0; i < 4; i++)
         m[8 * i +: 8] = {8{s_q.w_s[i]}};

      // write channel: address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_h = 1'b1;
         s_d.aw_a = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_h = 1'b1;
         s_d.w_d = s_axi_wdata;
         s_d.w_s = s_axi_wstrb;
      end
      if (s_q.bv && s_axi_bready)
         s_d.bv = 1'b0;
      if (s_q.aw_h && s_q.w_h && !s_q.bv) begin
         s_d.aw_h = 1'b0;
         s_d.w_h = 1'b0;
         s_d.bv = 1'b1;
         s_d.br = 2'b00;
         case (s_q.aw_a)
            `ADR_OFF_CTRL: begin
               if (s_q.w_s[0])
                  s_d.diag_en = s_q.w_d[0];
            end
            `ADR_OFF_REQ: begin
               if (!s_q.busy) begin
                  s_d.req = (s_q.req & ~m) | (s_q.w_d & m);
                  s_d.req_v = 1'b1;
                  s_d.busy = 1'b1;
                  s_d.done = 1'b0;
                  s_d.err = 1'b0;
                  s_d.cnt = 5'd0;
               end
            end
            `ADR_OFF_STAT: begin
               if (s_q.w_d[`ADR_ST_DONE] && m[`ADR_ST_DONE])
                  s_d.done = 1'b0;
               if (s_q.w_d[`ADR_ST_SEEN_IN] && m[`ADR_ST_SEEN_IN])
                  s_d.seen_in = 1'b0;
               if (s_q.w_d[`ADR_ST_SEEN_OUT] && m[`ADR_ST_SEEN_OUT])
                  s_d.seen_out = 1'b0;
               if (s_q.w_d[`ADR_ST_PRIT] && m[`ADR_ST_PRIT])
                  s_d.pend = 1'b0;
            end
            default: begin
               if (s_q.aw_a > `ADR_OFF_DATA_END)
                  s_d.br = 2'b10;
            end
         endcase
      end

      // read channel
      if (s_q.rv && s_axi_rready)
         s_d.rv = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rv = 1'b1;
         s_d.rr = 2'b00;
         s_d.rd = 32'h0;
         case (ra)
            `ADR_OFF_CTRL: s_d.rd = {31'h0, s_q.diag_en};
            `ADR_OFF_REQ: s_d.rd = s_q.req;
            `ADR_OFF_STAT: s_d.rd = stat;
            `ADR_OFF_PRIT: s_d.rd = {12'h000, s_q.plim, s_q.pstamp};
            default: begin
               if (ra >= `ADR_OFF_DATA && ra <= `ADR_OFF_DATA_END)
                  s_d.rd = s_q.rbuf[4 * (ra - `ADR_OFF_DATA) +: 4];
               else
                  s_d.rr = 2'b10;
            end
         endcase
      end

      // link side; hardware sets win over software clears
      if (link.req_valid && link.req_ready)
         s_d.req_v = 1'b0;
      if (link.rsp_valid && link.rsp_ready) begin
         if (!link.rsp_err)
            s_d.rbuf[s_q.cnt] = link.rsp_data;
         s_d.cnt = s_q.cnt + 5'd1;
         if (link.rsp_last) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.err = link.rsp_err;
         end
      end
      if (link.diag_in) begin
         s_d.act = 1'b1;
         s_d.seen_in = 1'b1;
      end
      if (link.diag_out) begin
         s_d.act = 1'b0;
         s_d.seen_out = 1'b1;
      end
      if (link.prit_valid && link.prit_ready) begin
         s_d.pend = 1'b1;
         s_d.pstamp = link.prit_stamp;
         s_d.plim = {link.prit_lower, link.prit_upper};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign s_axi_awready = !s_q.aw_h;
   assign s_axi_wready = !s_q.w_h;
   assign s_axi_bvalid = s_q.bv;
   assign s_axi_bresp = s_q.br;
   assign s_axi_arready = !s_q.rv;
   assign s_axi_rvalid = s_q.rv;
   assign s_axi_rdata = s_q.rd;
   assign s_axi_rresp = s_q.rr;
   assign link.diag_en = s_q.diag_en;
   assign link.req_valid = s_q.req_v;
   assign link.req_path = adr_pkg::adr_path_t'(s_q.req[1:0]);
   assign link.req_sub = s_q.req[15:8];
   assign link.req_sel = s_q.req[31:16];
   assign link.rsp_ready = s_q.busy;
   assign link.prit_ready = !s_q.pend;
endmodule
`default_nettype wire

// >>> bench/adr_link_asserts.sv
`default_nettype none
module adr_link_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic diag_en,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire adr_pkg::adr_path_t req_path,
   input wire logic [15:0] req_sel,
   input wire logic [7:0] req_sub,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last,
   input wire logic rsp_err,
   input wire logic diag_in,
   input wire logic diag_out,
   input wire logic prit_valid,
   input wire logic prit_ready,
   input wire logic [15:0] prit_stamp
);
   timeunit 1ns;
   timeprecision 1ns;
   logic act_q, act_d, eth_q, eth_d;
   logic [4:0] cnt_q, cnt_d, len_q, len_d;
   // beat count and expected length of the transfer under way
   always_comb begin
      act_d = (act_q | diag_in) & ~diag_out;
      cnt_d = cnt_q;
      len_d = len_q;
      eth_d = eth_q;
      if (req_valid && req_ready) begin
         cnt_d = 5'h00;
         eth_d = (req_path == adr_pkg::ADR_PATH_ETH);
         len_d = eth_d ? ((req_sub == 8'h13) ? 5'h04 : 5'h01)
                       : (req_sel[0] ? 5'h14 : 5'h04);
      end else if (rsp_valid && rsp_ready) begin
         cnt_d = cnt_q + 5'h01;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q <= 1'b0;
         eth_q <= 1'b0;
         cnt_q <= 5'h00;
         len_q <= 5'h00;
      end else begin
         act_q <= act_d;
         eth_q <= eth_d;
         cnt_q <= cnt_d;
         len_q <= len_d;
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_req;
      req_valid && req_ready;
   endsequence
   sequence s_stall;
      rsp_valid && !rsp_ready;
   endsequence
   a_req_answer: assert property (s_req |=> rsp_valid)
      else $error("no answer after request");
   a_rsp_stand: assert property (s_stall |=> rsp_valid &&
      $stable(rsp_data) && $stable(rsp_last))
      else $error("response byte not held");
   a_busy_refuse: assert property (rsp_valid |-> !req_ready)
      else $error("request open during send");
   a_rec_length: assert property (rsp_valid && rsp_ready &&
      rsp_last && !rsp_err |-> cnt_q == len_q - 5'h01)
      else $error("record length wrong");
   a_module_class: assert property (rsp_valid && !eth_q &&
      !rsp_err && cnt_q == 5'h01 |-> rsp_data == 8'h15)
      else $error("module info byte wrong");
   a_spare_zero: assert property (rsp_valid && !eth_q &&
      cnt_q == 5'h02 |-> rsp_data == 8'h00)
      else $error("spare byte not zero");
   a_err_empty: assert property (rsp_valid && rsp_err |->
      rsp_last && rsp_data == 8'h00)
      else $error("error reply malformed");
   a_no_second_in: assert property (diag_in |-> !act_q)
      else $error("second incoming while active");
   a_out_after_in: assert property (diag_out |-> act_q)
      else $error("going without incoming");
   a_in_enabled: assert property (diag_in |-> $past(diag_en))
      else $error("incoming while disabled");
   a_in_pulse: assert property (diag_in |=> !diag_in)
      else $error("incoming pulse too long");
   a_prit_stand: assert property (prit_valid && !prit_ready |=>
      prit_valid && $stable(prit_stamp))
      else $error("interrupt stamp not held");
endmodule
`default_nettype wire

// >>> bench/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int UC = 2;
   localparam logic [31:0] TQ [8] = '{32'h0001_0000, 32'h0000_0000,
      32'h2f00_0001, 32'h5005_0302, 32'h5005_1302, 32'h5005_1202,
      32'h0001_0003, 32'h0002_0000};
   localparam logic [4:0] TN [8] = '{5'h14, 5'h04, 5'h04, 5'h01, 5'h04,
      5'h00, 5'h00, 5'h00};
   typedef struct {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0] r;
   } adr_exp_t;
   logic aclk = 1'b0, aresetn = 1'b0, prit_event = 1'b0, lamp;
   logic [7:0] src = 8'h00, awa = 8'h00, ara = 8'h00;
   logic [1:0][7:0] chan_err = 16'h0000;
   logic [3:0] pq = 4'h0;
   logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
   logic awr, wrd, bvl, arr, rvl;
   logic [31:0] wdt = 32'h0, rdt;
   logic [1:0] brs, rrs;
   logic [15:0] lf = 16'hce72;
   int errors = 0, compares = 0, cyc = 0;
   adr_exp_t rq[$];
   logic [1:0] bq[$];
   always #10 aclk = ~aclk;
   always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
   adr_link_if lk ();
   adr_device #(.USEC_CYC(UC)) adr_device_inst (.aclk(aclk),
      .aresetn(aresetn), .link(lk), .module_fail(src[0]),
      .internal_err(src[1]), .external_err(src[2]), .aux_missing(src[4]),
      .diag_buf_overflow(src[5]), .comm_err(src[6]), .param_err(src[7]),
      .chan_err(chan_err), .prit_event(prit_event), .prit_upper(pq[1:0]),
      .prit_lower(pq[3:2]), .module_fault_lamp(lamp));
   adr_coupler adr_coupler_inst (.aclk(aclk), .aresetn(aresetn),
      .link(lk), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wdt), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs),
      .s_axi_bvalid(bvl), .s_axi_bready(brd), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
      .s_axi_rresp(rrs), .s_axi_rvalid(rvl), .s_axi_rready(rrd));
   adr_link_asserts adr_link_asserts_inst (.aclk(aclk), .aresetn(aresetn),
      .diag_en(lk.diag_en), .req_valid(lk.req_valid),
      .req_ready(lk.req_ready), .req_path(lk.req_path),
      .req_sel(lk.req_sel), .req_sub(lk.req_sub),
      .rsp_valid(lk.rsp_valid), .rsp_ready(lk.rsp_ready),
      .rsp_data(lk.rsp_data), .rsp_last(lk.rsp_last),
      .rsp_err(lk.rsp_err), .diag_in(lk.diag_in), .diag_out(lk.diag_out),
      .prit_valid(lk.prit_valid), .prit_ready(lk.prit_ready),
      .prit_stamp(lk.prit_stamp));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, e, m);
      compares++;
      if ((g & m) !== (e & m)) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic tmo();
      errors++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
   endtask
   // results are judged where they appear, one note per transfer
   always @(negedge aclk) begin
      adr_exp_t x;
      if (rvl && rrd && rq.size() > 0) begin
         x = rq.pop_front();
         cmp(rdt, x.d, x.m);
         cmp({30'h0, rrs}, {30'h0, x.r}, 32'h3);
      end
      if (bvl && brd && bq.size() > 0)
         cmp({30'h0, brs}, {30'h0, bq.pop_front()}, 32'h3);
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, hb;
      bq.push_back((a > 8'h23) ? 2'b10 : 2'b00);
      @(posedge aclk);
      awa <= a;
      wdt <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         ta = awv && awr;
         tw = wv && wrd;
         hb = bvl;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         n++;
      end while (!hb && n < 200);
      brd <= 1'b0;
      if (!hb) tmo();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                     output logic [31:0] g);
      int n;
      logic ta, h;
      rq.push_back(adr_exp_t'{e, m, (a > 8'h23) ? 2'b10 : 2'b00});
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         ta = arv && arr;
         h = rvl;
         g = rdt;
         @(posedge aclk);
         if (ta) arv <= 1'b0;
         n++;
      end while (!h && n < 200);
      rrd <= 1'b0;
      if (!h) tmo();
   endtask
   task automatic wl(input logic v);
      int n;
      n = 0;
      while (lamp !== v && n < 500) begin
         @(negedge aclk);
         n++;
      end
      if (lamp !== v) tmo();
      @(posedge aclk);
   endtask
   // request a record, poll for done, check status, clear done
   task automatic rec(input logic [31:0] q, e, m);
      int n;
      logic [31:0] g;
      wr(8'h04, q);
      n = 0;
      do begin
         rd(8'h08, 32'h0, 32'h0, g);
         n++;
      end while (g[1] !== 1'b1 && n < 50);
      if (g[1] !== 1'b1) tmo();
      rd(8'h08, e, m, g);
      wr(8'h08, 32'h2);
   endtask
   initial begin
      logic [31:0] g;
      logic [15:0] e;
      logic [7:0] m, s, x, c0, c1;
      int i;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 32'h0, 32'hffffffff, g);
      rd(8'h08, 32'h0, 32'hffffffff, g);
      rd(8'h40, 32'h0, 32'hffffffff, g);
      wr(8'h40, 32'h0);
      for (i = 0; i < 8; i++) begin
         rec(TQ[i], (TN[i] != 0) ? {19'h0, TN[i], 8'h02} : 32'h6,
             (TN[i] != 0) ? 32'h1f07 : 32'h6);
         if (i < 3) rd(8'h10, 32'h1500, 32'hffffffff, g);
         if (i == 3) rd(8'h10, 32'h15, 32'hff, g);
      end
      src <= 8'h10;
      repeat (20) @(posedge aclk);
      cmp({31'h0, lamp}, 32'h0, 32'h1);
      wr(8'h00, 32'h1);
      wl(1'b1);
      src <= 8'h00;
      wl(1'b0);
      for (i = 0; i < 8; i++) begin
         lf = nx(lf);
         m = 8'h01 << i;
         c0 = (i == 3) ? (lf[7:0] | 8'h01) : 8'h00;
         c1 = (i == 3) ? lf[15:8] : 8'h00;
         s = m & 8'h9f;
         x = (m & 8'h60) >> 2;
         src <= m;
         chan_err <= {c1, c0};
         wl(1'b1);
         e = 16'(cyc / UC);
         src <= m | 8'h80;
         rec(TQ[0] | ((i % 2) ? 32'h2f00_0001 : 32'h0), 32'h140a,
             32'h1f0f);
         rd(8'h10, {x, 8'h00, 8'h15, s}, 32'hffffffff, g);
         rd(8'h14, {6'h0, |c1, |c0, 24'h020871}, 32'hffffffff, g);
         rd(8'h18, {16'h0, c1, c0}, 32'hffffffff, g);
         rd(8'h1c, 32'h0, 32'hffffffff, g);
         // record stamp bytes hold the ticker at the incoming edge
         rd(8'h20, 32'h0, 32'h0, g);
         e = g[15:0] - e + 16'h0002;
         cmp({31'h0, e <= 16'h0004}, 32'h1, 32'h1);
         src <= 8'h00;
         chan_err <= 16'h0000;
         wl(1'b0);
         rd(8'h08, 32'h30, 32'h38, g);
         wr(8'h08, 32'h30);
      end
      for (i = 0; i < 4; i++) begin
         if (i == 3) wr(8'h08, 32'h40);
         lf = nx(lf);
         e = 16'(cyc / UC);
         prit_event <= 1'b1;
         pq <= lf[3:0];
         @(posedge aclk);
         prit_event <= 1'b0;
         @(posedge aclk);
         if (i == 0) begin
            rd(8'h0c, {12'h0, lf[3:0], 16'h0}, 32'h000f0000, g);
            e = g[15:0] - e + 16'h0002;
            cmp({31'h0, e <= 16'h0004}, 32'h1, 32'h1);
         end
         if (i == 2) begin
            wl(1'b1);
            rec(TQ[0], 32'h140a, 32'h1f0f);
            rd(8'h10, 32'h40001500, 32'hffffffff, g);
         end
      end
      wl(1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
